// File: core/rps_pkg.sv
// Notes on behaviour
// - local request starts guard; received messages ignored meanwhile
// - guard timer always runs to expiry
// - owner sends NR with RB on restore expiry
// - restore timer only in revertive mode
// - block wait equals guard plus five seconds
// - owner waits block timer after clearing commands
// - port failure reported only after hold-off recheck
// - owner keeps protection link blocked when idle
// - owner unblocks protection link on ring failure
// - neighbour also blocks its link end
// - exactly one ring link blocked at once, two when one node fails on both ports
// - revertive restore blocks protection link again
// - non-revertive keeps using protection link
// - failure switching completes well under 50ms
// - six independent rings with own state
// - control vlan created per ring, ring ports
// - version one block drops all vlans
// - version two block drops instance vlans only
// - instance holds control vlan, assignable to ring
// - each ring port controlled by one ring
// - every ring keeps its own message channel
// - guard 10 to 2000 ms, default 500
// - restore 5 to 720 s, default 300
// - hold-off 0 to 10000 ms, default 0
// - reject instance with mismatching control vlan
`default_nettype none
package rps_pkg;
  // ring and instance counts
  localparam int NRING = 6;
  localparam int NINST = 3;
  // clock and time base
  localparam int CLK_NS = 10;
  localparam int MS_NS  = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;
  localparam logic [19:0] MS_PER_S = 20'h003e8;
  localparam logic [12:0] WTB_EXTRA_MS = 13'h1388;
  // timer limits and reset values
  localparam logic [10:0] GRD_MIN = 11'h00a;
  localparam logic [10:0] GRD_MAX = 11'h7d0;
  localparam logic [10:0] GRD_RST = 11'h1f4;
  localparam logic [9:0]  WTR_MIN = 10'h005;
  localparam logic [9:0]  WTR_MAX = 10'h2d0;
  localparam logic [9:0]  WTR_RST = 10'h12c;
  localparam logic [13:0] HLD_MAX = 14'h2710;
  localparam logic [13:0] HLD_RST = 14'h0000;
  // register offsets inside a ring block, ring stride 16 bytes
  localparam logic [3:0] OFS_CFG = 4'h0;
  localparam logic [3:0] OFS_TMA = 4'h4;
  localparam logic [3:0] OFS_TMB = 4'h8;
  localparam logic [3:0] OFS_CMD = 4'hc;
  // field positions in the timer word
  localparam int GRD_LSB = 0;
  localparam int WTR_LSB = 16;
  // node roles
  localparam logic [1:0] ROLE_NORM  = 2'h0;
  localparam logic [1:0] ROLE_OWNER = 2'h1;
  localparam logic [1:0] ROLE_NEIGH = 2'h2;
  // request codes of ring messages
  localparam logic [1:0] REQ_NR = 2'h0;
  localparam logic [1:0] REQ_SF = 2'h1;
  localparam logic [1:0] REQ_MS = 2'h2;
  localparam logic [1:0] REQ_FS = 2'h3;
  // ring configuration word, bit 0 is en
  typedef struct packed {
    logic [11:0] cvlan;
    logic [1:0]  inst;
    logic        ver2;
    logic        revert;
    logic        rpl_r;
    logic [1:0]  role;
    logic        en;
  } rps_cfg_t;
  localparam rps_cfg_t CFG_RST = '0;
  // command word, bit 0 is fs
  typedef struct packed {
    logic eclr;
    logic clr;
    logic side;
    logic ms;
    logic fs;
  } rps_cmd_t;
  // ring message
  typedef struct packed {
    logic [1:0] req;
    logic       rb;
  } rps_msg_t;
  // blocking scope for the forwarding filter
  typedef struct packed {
    logic       all;
    logic [1:0] inst;
  } rps_scope_t;
  // protection states
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PROT = 5'h02,
    ST_MS   = 5'h04,
    ST_FS   = 5'h08,
    ST_PEND = 5'h10
  } rps_st_t;
  // status word
  typedef struct packed {
    logic       err;
    logic [1:0] rep;
    logic       wait_to_block_timer;
    logic       wtr;
    logic       grd;
    logic [1:0] blk;
    rps_st_t    st;
  } rps_stat_t;
endpackage
`default_nettype wire

// File: core/rps_ctrl.sv
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// millisecond down counter with reload on start
module rps_tmr #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // control
  input  wire logic         tick,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] val,
  // state
  output logic              run,
  output logic              done
);
  logic [W-1:0] cnt;  // remaining ms
  logic         arm;  // waiting for the first tick after start

  // load, count and expire; never expires short of the loaded ms
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cnt  <= '0;
      arm  <= 1'b0;
      run  <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt <= val;
        arm <= 1'b1;
        run <= 1'b1;
      end else if (stop) begin
        run <= 1'b0;
      end else if (run && cnt == '0) begin
        run  <= 1'b0;
        done <= 1'b1;
      end else if (run && tick && arm) begin
        arm <= 1'b0;  // partial first ms is not counted
      end else if (run && tick) begin
        cnt <= cnt - 1'b1;
      end
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_tmr_load: assert property (start |=> run && cnt == $past(val))
    else $error("timer not reloaded on start");
  a_tmr_keep: assert property ((run && cnt != '0 && !stop) |=> run)
    else $error("timer stopped before expiry");
endmodule

// ring protection control for all rings of the node
module rps_ctrl
  import rps_pkg::*;
#(
  parameter int MS_CYC_P = rps_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst,
  // register port
  input  wire logic [7:0]                           addr,
  input  wire logic [31:0]                          wdata,
  input  wire logic                                 wr,
  input  wire logic                                 rd,
  output logic [31:0]                               rdata_q,
  // port fault pins, one pair per ring
  input  wire logic [rps_pkg::NRING-1:0]            flt_l,
  input  wire logic [rps_pkg::NRING-1:0]            flt_r,
  // received messages, one channel per ring
  input  wire logic [rps_pkg::NRING-1:0]            rx_vld,
  input  wire rps_pkg::rps_msg_t [rps_pkg::NRING-1:0] rx_msg,
  // sent messages
  output logic [rps_pkg::NRING-1:0]                 tx_vld_q,
  output rps_pkg::rps_msg_t                         tx_msg_q [rps_pkg::NRING],
  // port blocking, bit 0 left, bit 1 right
  output logic [1:0]                                blk_q [rps_pkg::NRING],
  output rps_pkg::rps_scope_t                       scope_q [rps_pkg::NRING],
  // created control vlan, zero when ring is off
  output logic [11:0]                               cvlan_q [rps_pkg::NRING]
);
  import rps_pkg::*;

  rps_cfg_t             cfg_q [NRING];     // ring configuration
  logic [10:0]          grd_q [NRING];     // guard ms
  logic [9:0]           wtr_q [NRING];     // restore s
  logic [13:0]          hld_q [NRING];     // hold-off ms
  logic [11:0]          ivl_q [NINST];     // instance control vlan
  rps_stat_t            stat  [NRING];     // status words
  logic [NRING-1:0]     fl_m, fl_s, fr_m, fr_s;  // pin synchronisers
  logic [NRING-1:0]     fl_p, fr_p;        // delayed fault levels
  logic [16:0]          div_q;             // ms divider
  logic                 tick_q;            // ms enable pulse
  rps_cfg_t             wcfg;              // write data as config
  rps_cmd_t             wcmd;              // write data as command
  logic                 wr_bad;            // rejected config write

  assign wcfg = rps_cfg_t'(wdata[19:0]);
  assign wcmd = rps_cmd_t'(wdata[4:0]);

  // config or timer write out of range or vlan mismatch
  always_comb begin
    wr_bad = 1'b0;
    case (addr[3:0])
      OFS_CFG: wr_bad = wcfg.ver2 && wcfg.inst < 2'(NINST)
                        && ivl_q[wcfg.inst] != 12'h000
                        && ivl_q[wcfg.inst] != wcfg.cvlan;
      OFS_TMA: wr_bad = wdata[GRD_LSB +: 11] < GRD_MIN
                     || wdata[GRD_LSB +: 11] > GRD_MAX
                     || wdata[WTR_LSB +: 10] < WTR_MIN
                     || wdata[WTR_LSB +: 10] > WTR_MAX;
      OFS_TMB: wr_bad = wdata[13:0] > HLD_MAX;
      default: wr_bad = 1'b0;
    endcase
  end

  // two synchroniser flip-flops and one delay flip-flop on every fault pin
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      fl_m <= '0;
      fl_s <= '0;
      fr_m <= '0;
      fr_s <= '0;
      fl_p <= '0;
      fr_p <= '0;
    end else begin
      fl_m <= flt_l;
      fl_s <= fl_m;
      fr_m <= flt_r;
      fr_s <= fr_m;
      fl_p <= fl_s;
      fr_p <= fr_s;
    end
  end

  // common millisecond tick
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      div_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= (div_q == 17'(MS_CYC_P - 1));
      div_q  <= (div_q == 17'(MS_CYC_P - 1)) ? '0 : div_q + 1'b1;
    end
  end

  // instance table writes, one word per instance from 0x80
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NINST; i++) ivl_q[i] <= 12'h000;
    end else if (wr && addr[7] && addr[6:2] < 5'(NINST)) begin
      ivl_q[addr[3:2]] <= wdata[11:0];
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= '0;  // unmapped reads as zero
      if (rd && addr[7]) begin
        if (addr[6:2] < 5'(NINST)) rdata_q <= {20'h0, ivl_q[addr[3:2]]};
      end else if (rd && addr[6:4] < 3'(NRING)) begin
        case (addr[3:0])
          OFS_CFG: rdata_q <= {12'h0, cfg_q[addr[6:4]]};
          OFS_TMA: rdata_q <= {6'h0, wtr_q[addr[6:4]], 5'h0, grd_q[addr[6:4]]};
          OFS_TMB: rdata_q <= {18'h0, hld_q[addr[6:4]]};
          OFS_CMD: rdata_q <= {19'h0, stat[addr[6:4]]};
          default: rdata_q <= '0;
        endcase
      end
    end
  end

  // one independent control process per ring
  for (genvar g = 0; g < NRING; g++) begin : g_ring
    logic       sel;                  // this ring addressed
    logic       fs_p, ms_p, clr_p;    // command pulses
    logic       side;                 // command port
    logic       err_q;                // sticky write error
    logic [1:0] flt, flt_p;           // synchronised faults
    logic [1:0] hdone;                // hold-off expiry
    logic [1:0] rep_q, rep_d;         // reported failures
    logic       newrep, lreq, rx_ok;  // events
    logic       own, rpl_node;        // role decode
    logic [1:0] protection_link;                  // protection link port
    logic       grd_run, wtr_run, wtb_run, wtr_done, wtb_done;
    logic       wtr_go, wtb_go, tmr_stop;
    logic       loc_q, side_q, loc_n, side_n;  // local command
    logic       tx_p;                 // send request
    rps_msg_t   tmsg;                 // message to send
    rps_st_t    st_q, st_d;           // protection state
    logic [1:0] blk_d;                // next blocking

    assign sel   = !addr[7] && addr[6:4] == 3'(g);
    assign fs_p  = wr && sel && addr[3:0] == OFS_CMD && wcmd.fs;
    assign ms_p  = wr && sel && addr[3:0] == OFS_CMD && wcmd.ms;
    assign clr_p = wr && sel && addr[3:0] == OFS_CMD && wcmd.clr;
    assign side  = wcmd.side;
    assign flt   = {fr_s[g], fl_s[g]};
    assign flt_p = {fr_p[g], fl_p[g]};
    assign own      = cfg_q[g].role == ROLE_OWNER;
    assign rpl_node = cfg_q[g].role != ROLE_NORM;
    assign protection_link      = cfg_q[g].rpl_r ? 2'b10 : 2'b01;

    // ring register writes, rejected writes set the error
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        cfg_q[g] <= CFG_RST;
        grd_q[g] <= GRD_RST;
        wtr_q[g] <= WTR_RST;
        hld_q[g] <= HLD_RST;
        err_q    <= 1'b0;
      end else begin
        if (wr && sel && !wr_bad) begin
          case (addr[3:0])
            OFS_CFG: cfg_q[g] <= wcfg;
            OFS_TMA: begin
              grd_q[g] <= wdata[GRD_LSB +: 11];
              wtr_q[g] <= wdata[WTR_LSB +: 10];
            end
            OFS_TMB: hld_q[g] <= wdata[13:0];
            default: ;
          endcase
        end
        // set wins over clear
        if (wr && sel && wr_bad) err_q <= 1'b1;
        else if (wr && sel && addr[3:0] == OFS_CMD && wcmd.eclr) err_q <= 1'b0;
      end
    end

    // hold-off per port, restarted on each new fault
    for (genvar p = 0; p < 2; p++) begin : g_port
      rps_tmr #(.W(14)) u_hold (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick_q),
        .start   (flt[p] && !flt_p[p]),
        .stop    (!flt[p]),
        .val     (hld_q[g]),
        .run     (),
        .done    (hdone[p])
      );
    end

    // report only when the fault outlives the hold-off
    assign rep_d  = flt & (rep_q | hdone);
    assign newrep = |(rep_d & ~rep_q);
    assign lreq   = cfg_q[g].en && (newrep || fs_p || ms_p);
    assign rx_ok  = rx_vld[g] && !grd_run;

    rps_tmr #(.W(11)) u_grd (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick_q),
      .start   (lreq),
      .stop    (1'b0),
      .val     (grd_q[g]),
      .run     (grd_run),
      .done    ()
    );
    rps_tmr #(.W(20)) u_wtr (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick_q),
      .start   (wtr_go),
      .stop    (tmr_stop),
      .val     (20'(wtr_q[g]) * MS_PER_S),
      .run     (wtr_run),
      .done    (wtr_done)
    );
    rps_tmr #(.W(13)) u_wtb (
      .ref_clk (ref_clk),
      .rst     (rst),
      .tick    (tick_q),
      .start   (wtb_go),
      .stop    (tmr_stop),
      .val     (13'(grd_q[g]) + WTB_EXTRA_MS),
      .run     (wtb_run),
      .done    (wtb_done)
    );

    // next state, messages and timer starts
    always_comb begin
      st_d     = st_q;
      tx_p     = 1'b0;
      tmsg     = '0;
      wtr_go   = 1'b0;
      wtb_go   = 1'b0;
      tmr_stop = 1'b0;
      if (!cfg_q[g].en) begin
        st_d     = ST_IDLE;
        tmr_stop = 1'b1;
      end else if (newrep) begin
        st_d     = ST_PROT;
        tx_p     = 1'b1;
        tmsg.req = REQ_SF;
        tmr_stop = 1'b1;
      end else if (fs_p || (ms_p && st_q != ST_FS && st_q != ST_PROT)) begin
        st_d     = fs_p ? ST_FS : ST_MS;
        tx_p     = 1'b1;
        tmsg.req = fs_p ? REQ_FS : REQ_MS;
        tmr_stop = 1'b1;
      end else begin
        case (st_q)
          ST_IDLE: begin
            if (rx_ok && rx_msg[g].req == REQ_SF) st_d = ST_PROT;
            else if (rx_ok && rx_msg[g].req == REQ_FS) st_d = ST_FS;
            else if (rx_ok && rx_msg[g].req == REQ_MS) st_d = ST_MS;
          end
          ST_PROT: begin
            if (rx_ok && rx_msg[g].req == REQ_FS) begin
              st_d = ST_FS;
            end else if (rep_q != 2'b00 && rep_d == 2'b00) begin
              st_d     = ST_PEND;
              tx_p     = 1'b1;
              tmsg.req = REQ_NR;
              wtr_go   = own && cfg_q[g].revert;
            end else if (rep_q == 2'b00 && rx_ok
                         && rx_msg[g].req == REQ_NR) begin
              st_d   = ST_PEND;
              wtr_go = own && cfg_q[g].revert;
            end
          end
          ST_MS, ST_FS: begin
            if (clr_p && loc_q) begin
              st_d     = ST_PEND;
              tx_p     = 1'b1;
              tmsg.req = REQ_NR;
              wtb_go   = own;
            end else if (rx_ok && rx_msg[g].req == REQ_FS) begin
              st_d = ST_FS;
            end else if (!loc_q && rx_ok && rx_msg[g].req == REQ_NR) begin
              st_d   = ST_PEND;
              wtb_go = own;
            end
          end
          ST_PEND: begin
            if (rx_ok && rx_msg[g].req != REQ_NR) begin
              tmr_stop = 1'b1;
              case (rx_msg[g].req)
                REQ_SF:  st_d = ST_PROT;
                REQ_FS:  st_d = ST_FS;
                default: st_d = ST_MS;
              endcase
            end else if (wtr_done || wtb_done) begin
              st_d     = ST_IDLE;
              tx_p     = 1'b1;
              tmsg.req = REQ_NR;
              tmsg.rb  = 1'b1;
            end else if (!own && rx_ok && rx_msg[g].rb) begin
              st_d = ST_IDLE;
            end
          end
          default: st_d = ST_IDLE;
        endcase
      end
    end

    // local command ownership follows the state
    always_comb begin
      loc_n  = loc_q;
      side_n = side_q;
      if (fs_p || ms_p) begin
        loc_n  = 1'b1;
        side_n = side;
      end else if (st_d != ST_FS && st_d != ST_MS) begin
        loc_n = 1'b0;
      end
    end

    // blocked ports: protection link, failed ports (both when both fail) or forced or manually switched port
    always_comb begin
      case (st_d)
        ST_IDLE: blk_d = (cfg_q[g].en && rpl_node) ? protection_link : 2'b00;
        ST_PROT: blk_d = rep_d;
        ST_MS, ST_FS: blk_d = loc_n ? (side_n ? 2'b10 : 2'b01) : 2'b00;
        ST_PEND: blk_d = blk_q[g];
        default: blk_d = 2'b00;
      endcase
    end

    // state and local command flops
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        st_q   <= ST_IDLE;
        rep_q  <= 2'b00;
        loc_q  <= 1'b0;
        side_q <= 1'b0;
      end else begin
        st_q   <= st_d;
        rep_q  <= rep_d;
        loc_q  <= loc_n;
        side_q <= side_n;
      end
    end

    // outputs of this ring only
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        blk_q[g]    <= 2'b00;
        scope_q[g]  <= '0;
        tx_vld_q[g] <= 1'b0;
        tx_msg_q[g] <= '0;
        cvlan_q[g]  <= 12'h000;
      end else begin
        blk_q[g]         <= blk_d;
        scope_q[g].all   <= !cfg_q[g].ver2;
        scope_q[g].inst  <= cfg_q[g].inst;
        tx_vld_q[g]      <= tx_p;
        tx_msg_q[g]      <= tmsg;
        cvlan_q[g]       <= cfg_q[g].en ? cfg_q[g].cvlan : 12'h000;
      end
    end

    assign stat[g] = '{err: err_q, rep: rep_q, wait_to_block_timer: wtb_run, wtr: wtr_run,
                       grd: grd_run, blk: blk_q[g], st: st_q};

    a_wtr_send: assert property (@(posedge ref_clk) disable iff (rst)
      (wtr_done && st_q == ST_PEND && !newrep && !fs_p && !ms_p
       && cfg_q[g].en && !rx_ok)
      |=> tx_vld_q[g] && tx_msg_q[g].req == REQ_NR && tx_msg_q[g].rb)
      else $error("no NR RB after restore expiry");
    a_wtr_mode: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(wtr_run) |-> $past(cfg_q[g].revert) && $past(own))
      else $error("restore timer in non-revertive mode");
    a_wtb_arm: assert property (@(posedge ref_clk) disable iff (rst)
      (clr_p && loc_q && own && cfg_q[g].en && !newrep && !fs_p && !ms_p
       && (st_q == ST_FS || st_q == ST_MS)) |=> wtb_run && st_q == ST_PEND)
      else $error("block wait not started on clear");
    a_owner_idle: assert property (@(posedge ref_clk) disable iff (rst)
      (st_q == ST_IDLE && cfg_q[g].en && rpl_node && $stable(cfg_q[g]))
      |-> blk_q[g] == protection_link)
      else $error("protection link open in idle");
    a_fail_fast: assert property (@(posedge ref_clk) disable iff (rst)
      ($rose(rep_q[0]) && cfg_q[g].en) |-> blk_q[g][0])
      else $error("failed port not blocked");
    a_hold_rept: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(rep_q[1]) |-> $past(hdone[1]) && $past(flt[1]))
      else $error("failure reported without hold-off");
    a_rx_guard: assert property (@(posedge ref_clk) disable iff (rst)
      (grd_run && st_q == ST_IDLE && cfg_q[g].en && !lreq)
      |=> st_q == ST_IDLE)
      else $error("message acted on during guard");
    a_scope_ver: assert property (@(posedge ref_clk) disable iff (rst)
      $stable(cfg_q[g]) |=> scope_q[g].all == !$past(cfg_q[g].ver2))
      else $error("block scope disagrees with version");
  end
endmodule
`default_nettype wire

// File: test/rps_peer.sv
`timescale 1ns/1ps
`default_nettype none
// neighbour ring node: sends one message on its own ring channel
module rps_peer (
  // clock
  input  wire logic              ref_clk,
  // send request from the bench
  input  wire logic              go,
  input  wire rps_pkg::rps_msg_t m,
  // ring channel toward the node
  output logic                   vld,
  output rps_pkg::rps_msg_t      msg
);
  import rps_pkg::*;
  // one-cycle send; message inverts every cycle after, so it equals the old one every other cycle
  always_ff @(posedge ref_clk) begin
    vld <= go;
    msg <= go ? m : ~msg;
  end
endmodule
`default_nettype wire

// File: test/rps_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the ring protection control
module rps_ctrl_tb;
  import rps_pkg::*;
  localparam int MSC = 10; // cycles per ms, shortened
  // bus and pins
  logic            ref_clk = 1'b0;
  logic            rst = 1'b1;
  logic            wr = 1'b0;
  logic            rd = 1'b0;
  logic [7:0]      addr = '0;
  logic [31:0]     wdata = '0;
  logic [31:0]     rdata_q;
  logic [31:0]     v;
  logic [5:0]      flt_l = '0;
  logic [5:0]      flt_r = '0;
  logic [5:0]      go = '0;
  logic [5:0]      tx_vld_q;
  rps_msg_t        pm = '0;
  wire logic [5:0] rx_vld;
  wire rps_msg_t [5:0] rx_msg;
  rps_msg_t        tx_msg [NRING];
  logic [1:0]      blk [NRING];
  rps_scope_t      scope [NRING];
  logic [11:0]     cvlan [NRING];
  int              err_total = 0;
  int              samples_checked = 0;
  int              n;
  // device under test
  rps_ctrl #(.MS_CYC_P(MSC)) i_rps_ctrl (.ref_clk, .rst, .addr, .wdata,
    .wr, .rd, .rdata_q, .flt_l, .flt_r, .rx_vld, .rx_msg, .tx_vld_q,
    .tx_msg_q(tx_msg), .blk_q(blk), .scope_q(scope), .cvlan_q(cvlan));
  // one neighbour per ring channel
  for (genvar g = 0; g < NRING; g++) begin : g_peer
    rps_peer i_rps_peer (.ref_clk, .go(go[g]), .m(pm), .vld(rx_vld[g]),
      .msg(rx_msg[g]));
  end
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one-cycle register write
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask
  // register read, data in the cycle after the strobe
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata_q;
  endtask
  // wait for a sent message on ring r, n holds cycles waited
  // looks first at the pulse a write has just launched
  task automatic wtx(input int r, input int lim);
    n = 0;
    #1;
    while (tx_vld_q[r] !== 1'b1 && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
  endtask
  // neighbour sends a request on ring r
  task automatic snd(input int r, input logic [1:0] q);
    @(posedge ref_clk);
    pm    <= '{req: q, rb: 1'b0};
    go[r] <= 1'b1;
    @(posedge ref_clk);
    go[r] <= 1'b0;
  endtask
  // reset values and unmapped read
  task automatic t_reset;
    br(8'h04, v);
    chk(v, 32'h012c01f4);
    br(8'h08, v);
    chk(v, 32'h0);
    br(8'h0c, v);
    chk(v, 32'h1);
    br(8'h90, v);
    chk(v, 32'h0);
    $display("test reset done");
  endtask
  // owner: idle block, failure, guard, revertive restore start
  task automatic t_owner;
    bw(8'h04, 32'h00050009);
    br(8'h0c, v);
    chk(v[12], 1'b1);
    bw(8'h0c, 32'h10);
    br(8'h0c, v);
    chk(v[12], 1'b0);
    bw(8'h04, 32'h0005000a);
    bw(8'h00, 32'h6413);
    repeat (3) @(posedge ref_clk);
    chk(cvlan[0], 12'h064);
    chk(blk[0], 2'b01);
    chk(scope[0].all, 1'b1);
    flt_r[0] <= 1'b1;
    wtx(0, 20);
    chk(tx_msg[0].req, REQ_SF);
    chk(blk[0], 2'b10);
    snd(0, REQ_FS);
    br(8'h0c, v);
    chk(v[4:0], ST_PROT);
    repeat (150) @(posedge ref_clk);
    flt_r[0] <= 1'b0;
    wtx(0, 20);
    chk(tx_msg[0].req, REQ_NR);
    br(8'h0c, v);
    chk(v[8], 1'b1);
    chk(v[4:0], ST_PEND);
    bw(8'h00, 32'h6412);
    $display("test owner done");
  endtask
  // forced switch, clear, wait-to-block then re-block
  task automatic t_fs;
    bw(8'h00, 32'h6413);
    bw(8'h0c, 32'h5);
    wtx(0, 10);
    chk(tx_msg[0].req, REQ_FS);
    chk(blk[0], 2'b10);
    repeat (120) @(posedge ref_clk);
    bw(8'h0c, 32'h8);
    wtx(0, 10);
    chk(tx_msg[0].req, REQ_NR);
    chk(blk[0], 2'b10);
    @(posedge ref_clk); // let the NR pulse pass
    wtx(0, 51000);
    chk(n >= 50085 && n <= 50120, 1'b1);
    chk(tx_msg[0], {REQ_NR, 1'b1});
    chk(blk[0], 2'b01);
    $display("test fs done");
  endtask
  // hold-off: short glitch unreported, lasting fault reported late
  task automatic t_hold;
    bw(8'h10, 32'hc801);
    bw(8'h18, 32'h5);
    @(posedge ref_clk);
    flt_l[1] <= 1'b1;
    repeat (20) @(posedge ref_clk);
    flt_l[1] <= 1'b0;
    wtx(1, 100);
    chk(n, 100);
    @(posedge ref_clk);
    flt_l[1] <= 1'b1;
    wtx(1, 100);
    chk(n >= 50 && n <= 70, 1'b1);
    chk(blk[1], 2'b01);
    @(posedge ref_clk);
    flt_l[1] <= 1'b0;
    $display("test hold done");
  endtask
  // version 2 instance scope and vlan mismatch
  task automatic t_v2;
    bw(8'h84, 32'hc8);
    bw(8'h10, 32'hc961);
    br(8'h1c, v);
    chk(v[12], 1'b1);
    chk(cvlan[1], 12'h0c8);
    bw(8'h10, 32'hc861);
    repeat (3) @(posedge ref_clk);
    chk(scope[1], 3'b001);
    bw(8'h20, 32'h0d);
    repeat (2) @(posedge ref_clk);
    chk(blk[2], 2'b10);
    bw(8'h1c, 32'h2);
    wtx(1, 10);
    chk(tx_msg[1].req, REQ_MS);
    $display("test v2 done");
  endtask
  // counts, verdict and end of run
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset;
    t_owner;
    t_fs;
    t_hold;
    t_v2;
    print_verdict;
  end
  // watchdog, run needs about 51k cycles
  initial begin
    #800000;
    err_total++;
    print_verdict;
  end
endmodule
`default_nettype wire
